// ===== verification/tb_frt_timer.sv
// self-checking bench for the prescaled free-running timer over its apb port
module tb_frt_timer;
	import frt_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk_i = 1'b0; // 125 MHz system clock
	logic sys_rst_i = 1'b1; // held high for the first 20 cycles
	logic ce_i = 1'b1; // clock enable, dropped once to check freezing
	logic psel_i = 1'b0;
	logic penable_i = 1'b0;
	logic pwrite_i = 1'b0;
	logic [11:0] paddr_i = 12'h000;
	logic [31:0] pwdata_i = 32'h00000000;
	logic [31:0] prdata_o;
	logic pready_o;
	logic pslverr_o;
	int err_total = 0; // mismatches seen
	int samples_checked = 0; // comparisons made
	logic [31:0] rd; // read data taken at the pready edge
	logic er; // error flag taken at the same edge
	logic [7:0] cfg; // configuration byte under test
	frt_word_t t0; // first timer sample of a pair

	// free-running clock, 8 ns period
	always #4 mclk_i = ~mclk_i;

	// all strobes on so config always lands
	frt_timer u_dut (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .ce_i(ce_i), .psel_i(psel_i),
		.penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
		.pstrb_i(4'hf), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o));

	// prints the counts and the verdict, then stops the run
	task conclude;
		$display("mismatches %0d comparisons %0d", err_total, samples_checked);
		if (err_total == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : conclude

	// compares a data word
	task chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_total++;
			$display("BAD t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	// compares the slave error flag
	task chk_err(input logic got, input logic exp);
		chk({31'h0, got}, {31'h0, exp});
	endtask : chk_err

	// one apb transfer; entered right after a rising edge, leaves one idle edge behind
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel_i <= 1'b1;
		penable_i <= 1'b0;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge mclk_i);
		penable_i <= 1'b1;
		// the answer is sampled at the edge itself, before its own updates land
		do @(posedge mclk_i); while (pready_o !== 1'b1);
		rd = prdata_o;
		er = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
		// idle edge keeps the next request from reusing this time step
		@(posedge mclk_i);
	endtask : apb

	// main sequence
	initial begin
		repeat (20) @(posedge mclk_i);
		sys_rst_i <= 1'b0;
		apb(1'b0, 12'h000, 32'h0);
		chk(rd, 32'h0);
		apb(1'b0, 12'h004, 32'h0);
		chk(rd, 32'h0);
		// every prescale code, alternating the two variants' fixed bits
		for (int s = 0; s < 4; s++) begin
			cfg = {~s[0], 1'b0, s[1:0], 2'b00, s[0], 1'b1};
			apb(1'b1, 12'h000, {24'h0, cfg});
			apb(1'b0, 12'h000, 32'h0);
			chk(rd, {24'h0, cfg});
			chk_err(er, 1'b0);
			apb(1'b0, 12'h008, 32'h0);
			t0 = rd[15:0];
			// samples 128 cycles apart: a whole number of periods for every ratio
			repeat (124) @(posedge mclk_i);
			apb(1'b0, 12'h008, 32'h0);
			chk(rd, {16'h0, frt_word_t'(t0 + (128 >> (s + 2)))});
		end
		// clock enable low for 96 of 128 cycles: only one 1:8 step may happen
		apb(1'b0, 12'h008, 32'h0);
		t0 = rd[15:0];
		ce_i <= 1'b0;
		repeat (96) @(posedge mclk_i);
		ce_i <= 1'b1;
		repeat (28) @(posedge mclk_i);
		apb(1'b0, 12'h008, 32'h0);
		chk(rd, {16'h0, frt_word_t'(t0 + 16'h0001)});
		// disabled: the timer must not move
		apb(1'b1, 12'h000, 32'h00000030);
		apb(1'b0, 12'h008, 32'h0);
		t0 = rd[15:0];
		repeat (124) @(posedge mclk_i);
		apb(1'b0, 12'h008, 32'h0);
		chk(rd, {16'h0, t0});
		// far fewer than 65536 increments so far, so no overflow yet
		apb(1'b0, 12'h004, 32'h0);
		chk(rd, 32'h0);
		// read-only counter refuses a write and keeps its value
		apb(1'b1, 12'h004, 32'h0000ffff);
		chk_err(er, 1'b1);
		apb(1'b0, 12'h004, 32'h0);
		chk(rd, 32'h0);
		// unmapped place answers with an error and zero data
		apb(1'b0, 12'h00c, 32'h0);
		chk_err(er, 1'b1);
		chk(rd, 32'h0);
		conclude();
	end

	// watchdog: the sequence needs about 870 cycles
	initial begin
		repeat (5000) @(posedge mclk_i);
		err_total++;
		conclude();
	end
endmodule : tb_frt_timer

// ===== verilog/frt_cfg.svh
// register offsets, field positions, reset values and timing counts of the prescaled timer
`ifndef FRT_CFG_SVH
`define FRT_CFG_SVH
`define FRT_OFS_CONFIG 12'h000
`define FRT_OFS_COUNT 12'h004
`define FRT_OFS_TIMER 12'h008
`define FRT_BIT_EN 0
`define FRT_PRE_HI 5
`define FRT_PRE_LO 4
`define FRT_CONFIG_RST 8'h00
`define FRT_BASE_DIV 4
`endif

// ===== verilog/frt_pkg.sv
// types shared by the prescaled timer files
package frt_pkg;
	typedef enum logic [1:0] {
		FRT_APB_IDLE,
		FRT_APB_ACCESS
	} frt_apb_e;
	typedef logic [15:0] frt_word_t;
endpackage : frt_pkg

// ===== verilog/frt_tick.sv
// base tick divider followed by the selectable prescaler
module frt_tick
	import frt_pkg::*;
(
	input wire logic mclk_i,
	input wire logic sys_rst_i,
	input wire logic ce_i,
	input wire logic en_i,
	input wire logic [1:0] pre_i,
	output logic tick_o
);
`include "frt_cfg.svh"
	// whole state of the divider
	typedef struct packed {
		logic [1:0] base;
		logic [2:0] pre;
		logic tick;
	} frt_tick_s;
	frt_tick_s st_r;
	frt_tick_s st_nxt;
	logic [2:0] pre_last;
	// terminal prescale count: 2^sel - 1
	always_comb begin
		case (pre_i)
			2'h0: pre_last = 3'h0;
			2'h1: pre_last = 3'h1;
			2'h2: pre_last = 3'h3;
			default: pre_last = 3'h7;
		endcase
	end
	// next state: divide by four, then by the prescale
	always_comb begin
		st_nxt = st_r;
		st_nxt.tick = 1'b0;
		if (en_i) begin
			if (st_r.base == 2'(`FRT_BASE_DIV - 1)) begin
				st_nxt.base = 2'h0;
				if (st_r.pre >= pre_last) begin
					st_nxt.pre = 3'h0;
					st_nxt.tick = 1'b1;
				end else begin
					st_nxt.pre = st_r.pre + 3'h1;
				end
			end else begin
				st_nxt.base = st_r.base + 2'h1;
			end
		end
	end
	// state register; disabled dividers hold their phase
	always_ff @(posedge mclk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			st_r <= '0;
		end else if (ce_i) begin
			st_r <= st_nxt;
		end
	end
	assign tick_o = st_r.tick;
endmodule : frt_tick

// ===== verilog/frt_timer.sv
// free-running prescaled 16-bit timer with overflow word counter, APB slave
// Overview of operation
// - config bit 0 enables timer counting
// - bits 5:4 select prescale 1,2,4,8
// - base increment every four clock periods
// - overflow counter steps each 65536 increments
// - overflow counter is one readable 16-bit word
// - timer runs freely once enabled
//
// The implementer's own choices: the APB slave port and the register addresses.
module frt_timer
	import frt_pkg::*;
(
	input wire logic mclk_i,
	input wire logic sys_rst_i,
	input wire logic ce_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [11:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic [3:0] pstrb_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o
);
`include "frt_cfg.svh"
	// all state of the top in one struct
	typedef struct packed {
		logic [7:0] cfg;
		frt_word_t timer;
		frt_word_t count;
		logic [31:0] rdata;
		logic ready;
		logic err;
	} frt_top_s;
	frt_top_s st_r;
	frt_top_s st_nxt;
	logic tick; // one-cycle prescaled increment
	logic access; // apb access phase: psel and penable both high
	// divider chain lives in its own module
	frt_tick u_tick (
		.mclk_i(mclk_i),
		.sys_rst_i(sys_rst_i),
		.ce_i(ce_i),
		.en_i(st_r.cfg[`FRT_BIT_EN]),
		.pre_i(st_r.cfg[`FRT_PRE_HI:`FRT_PRE_LO]),
		.tick_o(tick)
	);
	// answer on the second access edge; the registered pready costs one wait state
	assign access = psel_i && penable_i;
	// next state of timer, counter and bus slave
	always_comb begin
		st_nxt = st_r;
		st_nxt.ready = 1'b0;
		st_nxt.err = 1'b0;
		// a tick only counts while enabled, so counts hold otherwise
		if (tick && st_r.cfg[`FRT_BIT_EN]) begin
			st_nxt.timer = st_r.timer + 16'h0001;
			if (st_r.timer == 16'hffff) begin
				st_nxt.count = st_r.count + 16'h0001;
			end
		end
		// first access cycle: decode, and raise the answer for the next edge
		if (access && !st_r.ready) begin
			st_nxt.ready = 1'b1;
			st_nxt.rdata = 32'h0000_0000;
			case (paddr_i)
				`FRT_OFS_CONFIG: begin
					st_nxt.rdata = {24'h00_0000, st_r.cfg};
				end
				`FRT_OFS_COUNT: begin
					st_nxt.rdata = {16'h0000, st_r.count};
					st_nxt.err = pwrite_i;
				end
				`FRT_OFS_TIMER: begin
					st_nxt.rdata = {16'h0000, st_r.timer};
					st_nxt.err = pwrite_i;
				end
				default: begin
					// unmapped address answers with an error
					st_nxt.err = 1'b1;
				end
			endcase
		end
		// the write lands only at the edge where the master sees pready high
		// fixed bits of either variant are stored as written, no check
		if (access && st_r.ready && pwrite_i && pstrb_i[0] && paddr_i == `FRT_OFS_CONFIG) begin
			st_nxt.cfg = pwdata_i[7:0];
		end
	end
	// state register
	always_ff @(posedge mclk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			st_r <= '0;
			st_r.cfg <= `FRT_CONFIG_RST;
		end else if (ce_i) begin
			st_r <= st_nxt;
		end
	end
	assign prdata_o = st_r.rdata;
	assign pready_o = st_r.ready;
	assign pslverr_o = st_r.err;
	// overflow word steps exactly when the timer wraps
	property p_wrap;
		@(posedge mclk_i) disable iff (sys_rst_i)
		(ce_i && tick && st_r.cfg[0] && st_r.timer == 16'hffff) |=> (st_r.count == $past(st_r.count) + 16'h0001);
	endproperty
	a_wrap: assert property (p_wrap) else $error("overflow count missed a wrap");
	// count holds unless the timer wraps
	property p_hold;
		@(posedge mclk_i) disable iff (sys_rst_i)
		!(ce_i && tick && st_r.cfg[0] && st_r.timer == 16'hffff) |=> $stable(st_r.count);
	endproperty
	a_hold: assert property (p_hold) else $error("overflow count changed without wrap");
	// disabled timer never moves
	property p_off;
		@(posedge mclk_i) disable iff (sys_rst_i)
		(!st_r.cfg[0] && !tick) |=> $stable(st_r.timer);
	endproperty
	a_off: assert property (p_off) else $error("timer moved while disabled");
	// at 1:1, enabled ticks come every fourth cycle
	sequence s_tick_gap;
		!tick [*3] ##1 tick;
	endsequence
	property p_base;
		@(posedge mclk_i) disable iff (sys_rst_i)
		(ce_i && tick && st_r.cfg[5:4] == 2'h0 && st_r.cfg[0]) ##1 (ce_i && st_r.cfg[5:4] == 2'h0 && st_r.cfg[0]) [*3]
		|-> ##1 tick;
	endproperty
	a_base: assert property (p_base) else $error("base tick spacing not four");
	// at 1:8 no tick within the 8 cycles after one
	property p_pre8;
		@(posedge mclk_i) disable iff (sys_rst_i)
		(ce_i && tick && st_r.cfg[5:4] == 2'h3) |=> !tick [*8];
	endproperty
	a_pre8: assert property (p_pre8) else $error("prescale 1:8 too fast");
	// bus answer comes one cycle into the access phase
	property p_ready;
		@(posedge mclk_i) disable iff (sys_rst_i)
		(ce_i && access && !pready_o) |=> pready_o;
	endproperty
	a_ready: assert property (p_ready) else $error("apb answer late");
	// count read returns the counter word
	property p_rd;
		@(posedge mclk_i) disable iff (sys_rst_i)
		(ce_i && access && !pready_o && !pwrite_i && paddr_i == `FRT_OFS_COUNT) |=>
		prdata_o == {16'h0000, $past(st_r.count)};
	endproperty
	a_rd: assert property (p_rd) else $error("count read mismatch");
	// enabled timer keeps advancing: a tick within 32 cycles
	property p_free;
		@(posedge mclk_i) disable iff (sys_rst_i)
		(ce_i && st_r.cfg[0]) [*8] |-> ##[0:32] (tick || !ce_i || !st_r.cfg[0]);
	endproperty
	a_free: assert property (p_free) else $error("enabled timer stalled");
	// an enabled tick moves the timer by exactly one
	property p_step;
		@(posedge mclk_i) disable iff (sys_rst_i)
		(ce_i && tick && st_r.cfg[0]) |=> (st_r.timer == $past(st_r.timer) + 16'h0001);
	endproperty
	a_step: assert property (p_step) else $error("timer step not one");
	// timer rolls over to zero on the wrapping tick
	property p_wrap_zero;
		@(posedge mclk_i) disable iff (sys_rst_i)
		(ce_i && tick && st_r.cfg[0] && st_r.timer == 16'hffff) |=> (st_r.timer == 16'h0000);
	endproperty
	a_wrap_zero: assert property (p_wrap_zero) else $error("timer did not roll over");
	// at 1:2 ticks are at least eight cycles apart
	property p_pre2;
		@(posedge mclk_i) disable iff (sys_rst_i)
		(ce_i && tick && st_r.cfg[5:4] == 2'h1) |=> !tick [*7];
	endproperty
	a_pre2: assert property (p_pre2) else $error("prescale 1:2 too fast");
	// at 1:4 no tick within the next eight cycles
	property p_pre4;
		@(posedge mclk_i) disable iff (sys_rst_i)
		(ce_i && tick && st_r.cfg[5:4] == 2'h2) |=> !tick [*8];
	endproperty
	a_pre4: assert property (p_pre4) else $error("prescale 1:4 too fast");
	// pready is a single-cycle pulse while the clock runs
	property p_pulse;
		@(posedge mclk_i) disable iff (sys_rst_i)
		(ce_i && pready_o) |=> !pready_o;
	endproperty
	a_pulse: assert property (p_pulse) else $error("pready held too long");
	// the error flag only ever travels with the answer
	property p_err_pulse;
		@(posedge mclk_i) disable iff (sys_rst_i)
		pslverr_o |-> pready_o;
	endproperty
	a_err_pulse: assert property (p_err_pulse) else $error("error without answer");
	// a write to a read-only or unmapped place is refused
	property p_ro_err;
		@(posedge mclk_i) disable iff (sys_rst_i)
		(ce_i && access && !pready_o && pwrite_i && paddr_i != `FRT_OFS_CONFIG) |=> pslverr_o;
	endproperty
	a_ro_err: assert property (p_ro_err) else $error("read-only write not refused");
	// config never moves before the answer edge, so an early write cannot land
	property p_no_early;
		@(posedge mclk_i) disable iff (sys_rst_i)
		(ce_i && access && !pready_o) |=> $stable(st_r.cfg);
	endproperty
	a_no_early: assert property (p_no_early) else $error("config changed before answer");
	// a config write lands at the edge that sees pready high
	property p_wr_land;
		@(posedge mclk_i) disable iff (sys_rst_i)
		(ce_i && access && pready_o && pwrite_i && pstrb_i[0] && paddr_i == `FRT_OFS_CONFIG) |=>
		(st_r.cfg == $past(pwdata_i[7:0]));
	endproperty
	a_wr_land: assert property (p_wr_land) else $error("config write lost");
endmodule : frt_timer
